// File: rtl/aadc_top.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// [R1] Sender side goes on-hook after thirty seconds of no carrier.
// [R2] Sender disconnect covers no start signal and end of transmission.
// [R3] Receiver side goes on-hook after thirty seconds of no carrier.
// [R4] Receiver disconnect covers wrong-number calls and end of transmission.
// [R5] Unattended selection: ring enters data mode and receiver starts motors.
// [R6] Far data set returns answer-back tone after answering.
// [R7] Data mode starts punch motor and tape drive motor.
// [R8] Punch stays idle from data mode until carrier arrives.
// [R9] Without unattended selection no automatic answer occurs.
// [R10] Selector gives the shared data set to one terminal only.
// [R11] Shared installations set selector to receive for unattended receiving.
// [R12] Four positions: send, receive, send-or-receive, test.
// [R13] Sender can be started without reverse channel carrier.
// [R14] Receiver resynchronizes after noise bursts.
// [R15] Carrier return restarts the thirty-second interval.
module aadc_top
    import aadc_pkg::*;
#(
    parameter int unsigned TICK_DIV = AADC_TICK_DIV,
    parameter int unsigned DISC_TICKS = AADC_DISC_TICKS
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire aadc_ds_s ds_i,
    input wire logic auto_i,
    input wire aadc_sel_e sel_i,
    input wire logic recv_req_i,
    input wire logic start_i,
    output aadc_dsctl_s ds_o,
    output logic send_own_o,
    output logic recv_own_o,
    output logic motors_o,
    output logic punch_en_o,
    output logic send_run_o,
    output logic test_o
);
    aadc_state_e state;
    aadc_state_e next_state;
    logic is_recv;
    logic seen_carrier;
    logic expire;

    // The timer needs a divider of two or more and at least one tick
    if (TICK_DIV < 2 || DISC_TICKS < 1) begin : g_bad_params
        $error("aadc_top: divider or tick count out of range");
    end

    // Selector decode; in combined position the role is picked per call
    wire sel_send = (sel_i == AADC_SEL_SEND); // R12
    wire sel_recv = (sel_i == AADC_SEL_RECV); // R12
    wire sel_both = (sel_i == AADC_SEL_BOTH); // R12
    wire sel_test = (sel_i == AADC_SEL_TEST); // R12
    wire next_recv = sel_recv || (sel_both && recv_req_i); // R10
    wire off_hook = (state == AADC_ST_WAIT) || (state == AADC_ST_LIVE);
    wire answer = ds_i.ring && auto_i && !sel_test; // R5 R9
    wire run_timer = off_hook && !ds_i.carrier; // R1 R3 R15

    // Shared thirty-second carrier-loss timer for either role
    aadc_timer #(
        .TICK_DIV(TICK_DIV),
        .TICKS(DISC_TICKS)
    ) u_timer (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .run_i(run_timer),
        .expire_o(expire)
    );

    // Call sequencer
    always_comb begin
        next_state = state;
        case (state)
            AADC_ST_IDLE: begin
                if (answer) begin
                    next_state = AADC_ST_WAIT; // R5
                end
            end
            AADC_ST_WAIT: begin
                if (expire) begin
                    next_state = AADC_ST_HANG; // R2 R4
                end else if (ds_i.carrier) begin
                    next_state = AADC_ST_LIVE;
                end
            end
            AADC_ST_LIVE: begin
                if (expire) begin
                    next_state = AADC_ST_HANG; // R2 R4
                end
            end
            AADC_ST_HANG: begin
                if (!ds_i.ring) begin
                    next_state = AADC_ST_IDLE;
                end
            end
            default: next_state = AADC_ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state <= AADC_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Role is latched at answer; send_own_o and recv_own_o still follow the selector mid-call
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            is_recv <= 1'b0;
        end else if (state == AADC_ST_IDLE) begin
            is_recv <= next_recv; // R10
        end
    end

    // Carrier has arrived since data mode began
    always_ff @(posedge mclk_i) begin
        if (srst_i || state == AADC_ST_IDLE) begin
            seen_carrier <= 1'b0;
        end else if (ds_i.carrier) begin
            seen_carrier <= 1'b1; // R8
        end
    end

    // Registered outputs
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ds_o <= '0;
            send_own_o <= 1'b0;
            recv_own_o <= 1'b0;
            motors_o <= 1'b0;
            punch_en_o <= 1'b0;
            send_run_o <= 1'b0;
            test_o <= 1'b0;
        end else begin
            ds_o.off_hook <= (next_state == AADC_ST_WAIT)
                || (next_state == AADC_ST_LIVE); // R1 R3
            ds_o.data_mode <= (next_state == AADC_ST_WAIT)
                || (next_state == AADC_ST_LIVE); // R5
            recv_own_o <= next_recv && !sel_test; // R10
            send_own_o <= sel_send || (sel_both && !recv_req_i); // R10
            motors_o <= is_recv && off_hook
                && (next_state != AADC_ST_HANG); // R7
            punch_en_o <= is_recv && (state == AADC_ST_LIVE)
                && (seen_carrier || ds_i.carrier); // R8 R14
            // Sender start needs no reverse channel, only a start pulse,
            // so it is accepted as soon as the line is off-hook
            send_run_o <= !is_recv && off_hook
                && (start_i || send_run_o); // R13
            test_o <= sel_test; // R12
        end
    end

    // Assertions
    sequence s_answered;
        state == AADC_ST_IDLE && answer;
    endsequence

    sequence s_recv_answer;
        s_answered ##1 is_recv;
    endsequence

    AST_NO_AUTO: assert property (@(posedge mclk_i) disable iff (srst_i) // R9
        !auto_i && state == AADC_ST_IDLE |=> state == AADC_ST_IDLE)
        else $error("answered without auto selection");
    AST_ANSWER: assert property (@(posedge mclk_i) disable iff (srst_i) // R5
        s_answered |=> state == AADC_ST_WAIT ##1 ds_o.data_mode)
        else $error("incoming call not answered");
    AST_HANG: assert property (@(posedge mclk_i) disable iff (srst_i) // R1
        expire && off_hook |=> state == AADC_ST_HANG ##1 !ds_o.off_hook)
        else $error("no on-hook after carrier loss");
    AST_PUNCH_IDLE: assert property (@(posedge mclk_i) disable iff (srst_i)
        punch_en_o |-> $past(seen_carrier || ds_i.carrier)) // R8
        else $error("punch ran before carrier");
    AST_MOTORS: assert property (@(posedge mclk_i) disable iff (srst_i) // R7
        is_recv && state == AADC_ST_LIVE && $stable(state) |-> motors_o)
        else $error("motors off in data mode");
    AST_EXCL: assert property (@(posedge mclk_i) disable iff (srst_i) // R10
        !(send_own_o && recv_own_o))
        else $error("both terminals own the data set");
    AST_CARRIER_HOLD: assert property (@(posedge mclk_i) disable iff (srst_i)
        ds_i.carrier [*2] |-> !expire) // R15
        else $error("timer expired with carrier present");
    AST_TEST: assert property (@(posedge mclk_i) disable iff (srst_i) // R12
        sel_test |=> test_o && !send_own_o && !recv_own_o)
        else $error("test position not isolated");

    // Receiver role: motors on after answer, punch blind until carrier
    AST_MOTOR_START: assert property (@(posedge mclk_i) // R7
        disable iff (srst_i) s_recv_answer |=> motors_o)
        else $error("motors not started after answer");
    AST_BLIND: assert property (@(posedge mclk_i) disable iff (srst_i) // R8
        state == AADC_ST_WAIT |=> !punch_en_o)
        else $error("punch enabled before carrier");
    AST_RESYNC: assert property (@(posedge mclk_i) disable iff (srst_i) // R14
        is_recv && state == AADC_ST_LIVE && $stable(state) |-> punch_en_o)
        else $error("punch not running in a live call");
    AST_RECV_HANG: assert property (@(posedge mclk_i) // R3
        disable iff (srst_i) expire && off_hook && is_recv |=> !ds_o.off_hook)
        else $error("receiver stayed off-hook after carrier loss");

    // Sender role: start without carrier, and stop on disconnect
    AST_SEND_HANG: assert property (@(posedge mclk_i) // R2
        disable iff (srst_i) expire && off_hook && !is_recv |=> !ds_o.off_hook)
        else $error("sender stayed off-hook after carrier loss");
    AST_SEND_RUN: assert property (@(posedge mclk_i) // R13
        disable iff (srst_i) !is_recv && off_hook && start_i |=> send_run_o)
        else $error("sender not started by start signal");
    AST_SEND_STOP: assert property (@(posedge mclk_i) // R2 R4
        disable iff (srst_i) state == AADC_ST_HANG |=> !send_run_o && !motors_o)
        else $error("terminal still running after disconnect");

    // Role holds for the whole call; hang-up waits for ring to clear
    AST_ROLE_HOLD: assert property (@(posedge mclk_i) // R10
        disable iff (srst_i) state != AADC_ST_IDLE |=> $stable(is_recv))
        else $error("terminal role changed during a call");
    AST_HANG_RELEASE: assert property (@(posedge mclk_i) // R4
        disable iff (srst_i) state == AADC_ST_HANG && !ds_i.ring
        |=> state == AADC_ST_IDLE)
        else $error("sequencer stuck after disconnect");
endmodule
`default_nettype wire

// File: rtl/aadc_pkg.sv
package aadc_pkg;
    // Timing of the disconnect interval
    localparam int unsigned AADC_CLK_HZ = 40_000_000;
    localparam int unsigned AADC_DISC_S = 30;
    localparam longint unsigned AADC_DISC_CYC = AADC_DISC_S * AADC_CLK_HZ;
    // Divider giving a one-millisecond tick
    localparam int unsigned AADC_TICK_HZ = 1000;
    localparam int unsigned AADC_TICK_DIV = AADC_CLK_HZ / AADC_TICK_HZ;
    localparam int unsigned AADC_DISC_TICKS = AADC_DISC_S * AADC_TICK_HZ;

    // Data set selector positions
    typedef enum logic [1:0] {
        AADC_SEL_SEND = 2'h0,
        AADC_SEL_RECV = 2'h1,
        AADC_SEL_BOTH = 2'h2,
        AADC_SEL_TEST = 2'h3
    } aadc_sel_e;

    // Answer sequencer states, one-hot
    typedef enum logic [3:0] {
        AADC_ST_IDLE = 4'h1,
        AADC_ST_WAIT = 4'h2,
        AADC_ST_LIVE = 4'h4,
        AADC_ST_HANG = 4'h8
    } aadc_state_e;

    // Data set lines seen by one terminal
    typedef struct packed {
        logic ring;
        logic carrier;
    } aadc_ds_s;

    // Controls returned to the data set
    typedef struct packed {
        logic off_hook;
        logic data_mode;
    } aadc_dsctl_s;
endpackage

// File: rtl/aadc_timer.sv
`timescale 1ns/10ps
`default_nettype none
// Carrier-loss timer: counts ms ticks of unbroken carrier absence
module aadc_timer
    import aadc_pkg::*;
#(
    parameter int unsigned TICK_DIV = AADC_TICK_DIV,
    parameter int unsigned TICKS = AADC_DISC_TICKS
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic run_i,
    output logic expire_o
);
    // Refuse counts that leave the divider no room to tick
    if (TICK_DIV < 2 || TICKS < 1) begin : g_bad_params
        $error("aadc_timer: bad divider or count");
    end


    logic [31:0] div_cnt;
    logic [31:0] tick_cnt;
    wire tick = (div_cnt == TICK_DIV - 1);
    wire done = (tick_cnt == TICKS);

    // Divider runs only while absent, so each restart is a full interval
    always_ff @(posedge mclk_i) begin
        if (srst_i || !run_i) begin
            div_cnt <= 32'h0; // R15
            tick_cnt <= 32'h0; // R15
        end else begin
            div_cnt <= tick ? 32'h0 : div_cnt + 32'h1;
            if (tick && !done) begin
                tick_cnt <= tick_cnt + 32'h1;
            end
        end
    end

    // Expire is a registered level held high while the count stays full
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            expire_o <= 1'b0;
        end else begin
            expire_o <= run_i && done;
        end
    end
endmodule
`default_nettype wire

// File: tb/aadc_dataset_model.sv
`timescale 1ns/10ps
`default_nettype none
// Data set on the line side: rings, answers, carries on request
module aadc_dataset_model
    import aadc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic call_i,
    input wire logic carrier_req_i,
    input wire aadc_dsctl_s ctl_i,
    output aadc_ds_s ds_o,
    output logic tone_o
);
    logic seen = 1'b0;
    logic ring = 1'b0;
    logic carr = 1'b0;
    // Ring stops once answered; a new call must first drop call_i
    always @(posedge mclk_i) begin
        seen <= call_i & (seen | ctl_i.off_hook);
        ring <= call_i & ~seen & ~ctl_i.off_hook;
        carr <= carrier_req_i & ctl_i.data_mode; // No carrier while on-hook
    end
    assign ds_o = '{ring: ring, carrier: carr};
    assign tone_o = seen & ctl_i.off_hook;
endmodule
`default_nettype wire

// File: tb/test_auto_answer_disconnect_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_auto_answer_disconnect_control;
    import aadc_pkg::*;
    // Short counts keep the thirty second wait at 20 cycles
    localparam int unsigned TDIV = 4;
    localparam int unsigned TCNT = 5;
    logic mclk_i = 1'b0, srst_i = 1'b1, auto_i = 1'b0, recv_req_i = 1'b0;
    logic start_i = 1'b0, call = 1'b0, carr = 1'b0;
    aadc_sel_e sel_i = AADC_SEL_RECV;
    aadc_ds_s ds;
    aadc_dsctl_s ctl;
    logic send_own, recv_own, motors, punch_en, send_run, test_q, tone;
    int bad_count = 0, tests_run = 0, n;
    aadc_top #(.TICK_DIV(TDIV), .DISC_TICKS(TCNT)) DUT (.mclk_i(mclk_i),
        .srst_i(srst_i), .ds_i(ds), .auto_i(auto_i), .sel_i(sel_i),
        .recv_req_i(recv_req_i), .start_i(start_i), .ds_o(ctl),
        .send_own_o(send_own), .recv_own_o(recv_own), .motors_o(motors),
        .punch_en_o(punch_en), .send_run_o(send_run), .test_o(test_q));
    aadc_dataset_model line (.mclk_i(mclk_i), .call_i(call),
        .carrier_req_i(carr), .ctl_i(ctl), .ds_o(ds), .tone_o(tone));
    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic step(input int c);
        repeat (c) @(negedge mclk_i);
    endtask
    task automatic drive_carrier(input logic v);
        @(posedge mclk_i);
        carr <= v;
    endtask
    // A call arrives with the given selector and role settings
    task automatic ring_in(input aadc_sel_e s, input logic a, input logic r);
        @(posedge mclk_i);
        sel_i <= s;
        auto_i <= a;
        recv_req_i <= r;
        call <= 1'b1;
    endtask
    task automatic wait_hook(input logic v, input int lim);
        n = 0;
        while (ctl.off_hook !== v && n < lim) begin
            step(1);
            n++;
        end
    endtask
    task automatic end_call(input string name);
        @(posedge mclk_i);
        call <= 1'b0;
        carr <= 1'b0;
        start_i <= 1'b0;
        step(3);
        $display("test %s done", name);
    endtask
    // Hang guard: the tests need well under 2000 cycles
    initial begin
        #(25 * 2000);
        bad_count++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge mclk_i);
        srst_i <= 1'b0;
        step(1);
        check("reset hook", {ctl, motors, punch_en, send_run}, 8'h00);
        ring_in(AADC_SEL_RECV, 1'b0, 1'b0);
        step(25);
        check("manual hook", ctl.off_hook, 8'h00);
        end_call("manual");
        ring_in(AADC_SEL_TEST, 1'b1, 1'b0);
        step(25);
        check("test pos", {test_q, ctl.off_hook}, 8'h02);
        end_call("test");
        ring_in(AADC_SEL_RECV, 1'b1, 1'b0);
        wait_hook(1'b1, 10);
        step(1); // Tone and motors follow the hook by one edge
        check("answer", {ctl, tone}, 8'h07);
        check("motors", motors, 8'h01);
        check("owner", {recv_own, send_own}, 8'h02);
        step(10);
        check("blind", punch_en, 8'h00);
        drive_carrier(1'b1);
        step(5);
        check("punch", punch_en, 8'h01);
        drive_carrier(1'b0);
        step(15);
        check("gap hook", ctl.off_hook, 8'h01);
        drive_carrier(1'b1);
        step(3);
        check("resync punch", punch_en, 8'h01);
        drive_carrier(1'b0);
        step(15);
        check("restart", ctl.off_hook, 8'h01);
        wait_hook(1'b0, 60);
        check("recv drop", 15 + n >= 20 && 15 + n <= 28, 8'h01);
        end_call("receive");
        ring_in(AADC_SEL_RECV, 1'b1, 1'b0);
        wait_hook(1'b1, 10);
        wait_hook(1'b0, 60);
        check("wrong num", n >= 18 && n <= 30, 8'h01);
        end_call("wrong number");
        // Send, send/receive as sender, send/receive as receiver
        for (int i = 0; i < 3; i++) begin
            ring_in(i == 0 ? AADC_SEL_SEND : AADC_SEL_BOTH, 1'b1, i == 2);
            wait_hook(1'b1, 10);
            step(1);
            check("role", {recv_own, send_own, motors},
                  i == 2 ? 8'h05 : 8'h02);
            if (i == 0) begin
                @(posedge mclk_i);
                start_i <= 1'b1;
                step(3);
                check("send run", send_run, 8'h01);
            end
            wait_hook(1'b0, 60);
            check("send drop", n >= 15 && n <= 30, 8'h01);
            end_call("role");
        end
        close_out();
    end
endmodule
`default_nettype wire
